// ### lsd_line_stats.sv
// Purpose: Video path with end-of-line statistics trailer, test patterns
//   and single or averaged line readback for the microcontroller.
// Assumes: Input video is the pre-correction stream; line gaps of at
//   least 17 clocks; Wishbone classic slave with 32-bit data.
// Notes: All outputs are registered.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module lsd_line_stats
  import lsd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Video in and out.
  input wire lsd_beat_t vid_i,
  output lsd_beat_t vid_o
);

  ////////////////////////////////////////////////////////////////////////
  // Functions.

  // Merges write data into a register under the byte selects.
  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Clamps a pixel position into lo..LSD_RES.
  function automatic logic [11:0] clamp(input logic [11:0] v,
                                        input logic [11:0] lo);
    logic [11:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > 12'(LSD_RES)) begin
      r = 12'(LSD_RES);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and state.

  logic els_en;
  lsd_src_t src;
  logic [11:0] upper, lower, roi_s, roi_e, rb_s, rb_e, rb_idx;
  logic [10:0] nlines;
  lsd_beat_t s1;
  logic [11:0] icol, col;
  logic prev_lval, prev_ok;
  logic [11:0] prev_pix;
  logic [31:0] sum, dsum, snap_sum, snap_dsum;
  logic [15:0] above, below, snap_above, snap_below;
  logic [3:0] lc, snap_lc, tr_idx;
  logic tr_act;
  lsd_rb_t rb_st;
  logic [LSD_AW-1:0] acc [LSD_RES];
  logic [10:0] rb_line;
  logic rb_first;
  logic [11:0] st_min, st_max, st_cnt, mean;
  logic [23:0] st_sum, dv;
  logic [12:0] rem;
  logic [4:0] dcnt;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire bus_req = cyc_i && stb_i && !ack_o;
  wire bus_wr = bus_req && we_i;
  wire [31:0] wr_ctrl = wmask({29'h0, src, els_en}, dat_i, sel_i);
  wire [31:0] wr_up = wmask({20'h0, upper}, dat_i, sel_i);
  wire [31:0] wr_lo = wmask({20'h0, lower}, dat_i, sel_i);
  wire [31:0] wr_roi = wmask({4'h0, roi_e, 4'h0, roi_s}, dat_i, sel_i);
  wire [31:0] wr_rb = wmask({4'h0, rb_e, 4'h0, rb_s}, dat_i, sel_i);
  wire [31:0] wr_ns = wmask({21'h0, nlines}, dat_i, sel_i);
  wire [31:0] wr_ix = wmask({20'h0, rb_idx}, dat_i, sel_i);
  wire ns_ok = wr_ns[31:0] == {21'h0, LSD_N256} ||
               wr_ns[31:0] == {21'h0, LSD_N512} ||
               wr_ns[31:0] == {21'h0, LSD_N1024};
  wire src_ok = wr_ctrl[2:1] != 2'b11;
  // Effective readback end: never below the start.
  wire [11:0] eff_e = (rb_e <= rb_s) ? rb_s : rb_e;
  wire rb_busy = rb_st != LSD_RB_IDLE && rb_st != LSD_RB_DONE;
  wire idx_in = rb_idx >= rb_s && rb_idx <= eff_e && rb_idx != 12'h000;
  wire [LSD_AW-1:0] acc_rd = acc[11'(rb_idx - 12'h001)];
  wire [31:0] rb_word = (idx_in && rb_st == LSD_RB_DONE) ?
                        {20'h0, acc_rd[11:0]} : 32'h0;

  // Read multiplexer; unmapped addresses read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    case (adr_i)
      LSD_CTRL: rd_mux = {29'h0, src, els_en};
      LSD_UPPER: rd_mux = {20'h0, upper};
      LSD_LOWER: rd_mux = {20'h0, lower};
      LSD_ROI: rd_mux = {4'h0, roi_e, 4'h0, roi_s};
      LSD_RBRANGE: rd_mux = {4'h0, rb_e, 4'h0, rb_s};
      LSD_SAMPLES: rd_mux = {21'h0, nlines};
      LSD_CMD: rd_mux = {30'h0, rb_st == LSD_RB_DONE, rb_busy};
      LSD_RBIDX: rd_mux = {20'h0, rb_idx};
      LSD_RBDATA: rd_mux = rb_word;
      LSD_MINMAX: rd_mux = {4'h0, st_max, 4'h0, st_min};
      LSD_MEAN: rd_mux = {20'h0, mean};
      LSD_LINECNT: rd_mux = {28'h0, lc};
      default: rd_mux = 32'h0;
    endcase
  end

  // Acknowledge one cycle after a request, dropped the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_mux : 32'h0;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      els_en <= LSD_ELS_RST;
      src <= LSD_SRC_LIVE;
      upper <= LSD_UPPER_RST;
      lower <= LSD_LOWER_RST;
      roi_s <= LSD_POS_RST;
      roi_e <= LSD_END_RST;
      rb_s <= LSD_POS_RST;
      rb_e <= LSD_END_RST;
      rb_idx <= LSD_POS_RST;
      nlines <= LSD_N1024;
    end else if (bus_wr) begin
      case (adr_i)
        LSD_CTRL: begin
          els_en <= wr_ctrl[LSD_F_ELS];
          if (src_ok) begin
            src <= lsd_src_t'(wr_ctrl[LSD_F_SRC +: 2]);
          end
        end
        LSD_UPPER: upper <= wr_up[11:0];
        LSD_LOWER: lower <= wr_lo[11:0];
        LSD_ROI: begin
          roi_s <= clamp(wr_roi[11:0], LSD_POS_RST);
          roi_e <= clamp(wr_roi[LSD_F_HI +: 12], LSD_POS_RST);
        end
        LSD_RBRANGE: begin
          rb_s <= clamp(wr_rb[11:0], LSD_POS_RST);
          rb_e <= clamp(wr_rb[LSD_F_HI +: 12], LSD_RB_END_MIN);
        end
        LSD_SAMPLES: begin
          if (ns_ok) begin
            nlines <= wr_ns[10:0];
          end
        end
        LSD_RBIDX: rb_idx <= wr_ix[11:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Video source and statistics.

  wire [11:0] ramp = icol;
  wire [11:0] step = {4'h0, icol[11:4]};
  wire [11:0] src_pix = (src == LSD_SRC_RAMP) ? ramp :
                        (src == LSD_SRC_STEP) ? step : vid_i.data;
  wire line_end = prev_lval && !s1.lval;
  wire [11:0] pnum = col + 12'h001;
  wire in_roi = s1.lval && pnum >= roi_s && pnum <= roi_e;
  wire [11:0] adiff = (s1.data >= prev_pix) ? s1.data - prev_pix :
                      prev_pix - s1.data;

  // Source select stage and column counters.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      icol <= 12'h0;
      col <= 12'h0;
      prev_lval <= 1'b0;
    end else begin
      s1.lval <= vid_i.lval;
      s1.data <= vid_i.lval ? src_pix : 12'h0;
      icol <= vid_i.lval ? icol + 12'h001 : 12'h0;
      col <= s1.lval ? col + 12'h001 : 12'h0;
      prev_lval <= s1.lval;
    end
  end

  // Per-line accumulators over the region of interest.
  always_ff @(posedge clk_i) begin
    if (rst_i || line_end) begin
      sum <= 32'h0;
      dsum <= 32'h0;
      above <= 16'h0;
      below <= 16'h0;
      prev_ok <= 1'b0;
      prev_pix <= 12'h0;
    end else if (in_roi) begin
      sum <= sum + {20'h0, s1.data};
      above <= (s1.data > upper) ? above + 16'h1 : above;
      below <= (s1.data < lower) ? below + 16'h1 : below;
      dsum <= prev_ok ? dsum + {20'h0, adiff} : dsum;
      prev_ok <= 1'b1;
      prev_pix <= s1.data;
    end
  end

  // Snapshot at line end, line counter and trailer sequencing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {snap_sum, snap_dsum, snap_above, snap_below} <= '0;
      snap_lc <= 4'h0;
      lc <= 4'h0;
      tr_act <= 1'b0;
      tr_idx <= 4'h0;
    end else if (line_end) begin
      {snap_sum, snap_dsum} <= {sum, dsum};
      {snap_above, snap_below} <= {above, below};
      snap_lc <= lc;
      lc <= lc + 4'h1;
      tr_act <= els_en;
      tr_idx <= 4'h0;
    end else if (tr_act) begin
      tr_idx <= tr_idx + 4'h1;
      tr_act <= tr_idx != LSD_TR_LAST;
    end
  end

  // Trailer word selection, bytes in the low bits.
  logic [7:0] tr_byte;
  always_comb begin
    case (tr_idx)
      4'h0, 4'h2: tr_byte = LSD_PAT_A;
      4'h1: tr_byte = LSD_PAT_5;
      4'h3: tr_byte = {4'h0, snap_lc};
      4'h4, 4'h5, 4'h6, 4'h7:
        tr_byte = snap_sum[8*(tr_idx - 4'h4) +: 8];
      4'h8: tr_byte = snap_above[7:0];
      4'h9: tr_byte = snap_above[15:8];
      4'ha: tr_byte = snap_below[7:0];
      4'hb: tr_byte = snap_below[15:8];
      default: tr_byte = snap_dsum[8*(tr_idx - 4'hc) +: 8];
    endcase
  end

  // Video output; line valid is low while trailer words go out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_o <= '0;
    end else if (tr_act) begin
      vid_o.lval <= 1'b0;
      vid_o.data <= {4'h0, tr_byte};
    end else begin
      vid_o <= s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line readback: single line or average over nlines.

  wire cmd_wr = bus_wr && adr_i == LSD_CMD && sel_i[0] && !rb_busy;
  wire go_single = cmd_wr && dat_i[LSD_F_SINGLE];
  wire go_avg = cmd_wr && dat_i[LSD_F_AVG] && !dat_i[LSD_F_SINGLE];
  wire rb_last = rb_line == 11'h001;
  wire [3:0] shift = (nlines == LSD_N256) ? 4'd8 :
                     (nlines == LSD_N512) ? 4'd9 : 4'd10;
  wire [3:0] rb_sh;
  logic rb_avg;
  assign rb_sh = rb_avg ? shift : 4'd0;
  wire [LSD_AW-1:0] acc_cur = acc[col[10:0]];
  wire [LSD_AW-1:0] acc_new = rb_first ? {10'h0, s1.data} :
                              acc_cur + {10'h0, s1.data};
  wire [LSD_AW-1:0] acc_fin = acc_new >> rb_sh;
  wire capt = rb_st == LSD_RB_CAPT && s1.lval;
  wire fin_roi = capt && rb_last && in_roi;
  wire [12:0] rem_sh = {rem[11:0], dv[23]};

  // Pixel store; the last line leaves the scaled mean in place.
  always_ff @(posedge clk_i) begin
    if (capt) begin
      acc[col[10:0]] <= rb_last ? acc_fin : acc_new;
    end
  end

  // Readback sequencer and ROI minimum, maximum and mean.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rb_st <= LSD_RB_IDLE;
      rb_line <= 11'h0;
      rb_first <= 1'b0;
      rb_avg <= 1'b0;
      {st_min, st_max, st_cnt, mean} <= '0;
      {st_sum, dv, rem, dcnt} <= '0;
    end else begin
      case (rb_st)
        LSD_RB_IDLE, LSD_RB_DONE: begin
          if (go_single || go_avg) begin
            rb_st <= LSD_RB_ARM;
            rb_avg <= go_avg;
            rb_line <= go_avg ? nlines : 11'h001;
            rb_first <= 1'b1;
            st_min <= 12'hfff;
            {st_max, st_cnt, st_sum} <= '0;
          end
        end
        LSD_RB_ARM: begin
          if (!s1.lval) begin
            rb_st <= LSD_RB_CAPT;
          end
        end
        LSD_RB_CAPT: begin
          if (fin_roi) begin
            st_min <= (acc_fin[11:0] < st_min) ? acc_fin[11:0] : st_min;
            st_max <= (acc_fin[11:0] > st_max) ? acc_fin[11:0] : st_max;
            st_sum <= st_sum + {12'h0, acc_fin[11:0]};
            st_cnt <= st_cnt + 12'h001;
          end
          if (line_end) begin
            rb_first <= 1'b0;
            rb_line <= rb_line - 11'h001;
            if (rb_last) begin
              rb_st <= LSD_RB_DIV;
              dv <= st_sum;
              rem <= 13'h0;
              dcnt <= LSD_DIV_STEPS;
              mean <= 12'h0;
            end
          end
        end
        LSD_RB_DIV: begin
          // Restoring division of the ROI sum by the ROI pixel count.
          dv <= {dv[22:0], 1'b0};
          if (st_cnt != 12'h0 && rem_sh >= {1'b0, st_cnt}) begin
            rem <= rem_sh - {1'b0, st_cnt};
            mean <= {mean[10:0], 1'b1};
          end else begin
            rem <= rem_sh;
            mean <= {mean[10:0], 1'b0};
          end
          dcnt <= dcnt - 5'h01;
          if (dcnt == 5'h01) begin
            rb_st <= LSD_RB_DONE;
          end
        end
        default: rb_st <= LSD_RB_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_trailer_lval_low: assert property (tr_act |=> !vid_o.lval)
    else $error("line valid high during trailer");
  a_trailer_off: assert property (line_end && !els_en |=> !tr_act)
    else $error("trailer started while disabled");
  a_trailer_len: assert property (line_end && els_en |=>
    tr_act [*8] ##1 tr_act [*8] ##1 !tr_act)
    else $error("trailer is not sixteen words");
  a_check_pattern: assert property ($rose(tr_act) |=>
    vid_o.data == 12'h0aa ##1 vid_o.data == 12'h055
    ##1 vid_o.data == 12'h0aa)
    else $error("check pattern wrong");
  a_line_counter: assert property (line_end |=>
    lc == 4'($past(lc) + 4'h1) && snap_lc == $past(lc))
    else $error("line counter did not advance");
  a_upper_zero: assert property (tr_act |=> vid_o.data[11:8] == 4'h0)
    else $error("upper trailer bits not zero");
  a_sum_first: assert property ($rose(tr_act) |-> ##5
    vid_o.data[7:0] == snap_sum[7:0])
    else $error("line sum low byte not first");
  a_above_count: assert property (in_roi && s1.data > upper |=>
    above == $past(above) + 16'h1)
    else $error("above count missed a pixel");
  a_below_count: assert property (in_roi && s1.data >= lower |=>
    below == $past(below))
    else $error("below count took equal pixel");
  a_diff_sum: assert property (in_roi && prev_ok |=>
    dsum == $past(dsum) + {20'h0, $past(adiff)})
    else $error("differential sum wrong");
  a_roi_only: assert property (s1.lval && !in_roi |=>
    sum == $past(sum))
    else $error("pixel outside ROI summed");
  a_src_legal: assert property (src != 2'b11)
    else $error("illegal source select");
  a_ramp_path: assert property (src == LSD_SRC_RAMP && vid_i.lval |=>
    s1.data == $past(icol))
    else $error("ramp pattern wrong");
  a_rb_range: assert property (eff_e >= rb_s && rb_e >= LSD_RB_END_MIN &&
    rb_s >= LSD_POS_RST)
    else $error("readback range illegal");
  a_css_legal: assert property (nlines == LSD_N256 ||
    nlines == LSD_N512 || nlines == LSD_N1024)
    else $error("illegal sample count");
  a_div_time: assert property (rb_st == LSD_RB_CAPT && line_end &&
    rb_last |-> ##25 rb_st == LSD_RB_DONE)
    else $error("mean not ready in time");

  c_trailer: cover property ($rose(tr_act) ##16 !tr_act);
  c_single_done: cover property (!rb_avg && $rose(rb_st == LSD_RB_DONE));
  c_avg_done: cover property (rb_avg && $rose(rb_st == LSD_RB_DONE));
  c_step_src: cover property (src == LSD_SRC_STEP && s1.lval);

endmodule // lsd_line_stats
`default_nettype wire

// ### lsd_pkg.sv
// Purpose: Constants and types for the line statistics diagnostics block.
// Assumes: 12-bit video, one pixel per clock, sensor of LSD_RES pixels.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package lsd_pkg;

  localparam int LSD_RES = 2048;
  localparam int LSD_PW = 12;
  localparam int LSD_AW = 22;

  // Register byte offsets.
  localparam logic [7:0] LSD_CTRL = 8'h00;
  localparam logic [7:0] LSD_UPPER = 8'h04;
  localparam logic [7:0] LSD_LOWER = 8'h08;
  localparam logic [7:0] LSD_ROI = 8'h0c;
  localparam logic [7:0] LSD_RBRANGE = 8'h10;
  localparam logic [7:0] LSD_SAMPLES = 8'h14;
  localparam logic [7:0] LSD_CMD = 8'h18;
  localparam logic [7:0] LSD_RBIDX = 8'h1c;
  localparam logic [7:0] LSD_RBDATA = 8'h20;
  localparam logic [7:0] LSD_MINMAX = 8'h24;
  localparam logic [7:0] LSD_MEAN = 8'h28;
  localparam logic [7:0] LSD_LINECNT = 8'h2c;

  // Field positions.
  localparam int LSD_F_ELS = 0;
  localparam int LSD_F_SRC = 1;
  localparam int LSD_F_HI = 16;
  localparam int LSD_F_SINGLE = 0;
  localparam int LSD_F_AVG = 1;

  // Reset values.
  localparam logic LSD_ELS_RST = 1'b1;
  localparam logic [11:0] LSD_UPPER_RST = 12'hfff;
  localparam logic [11:0] LSD_LOWER_RST = 12'h000;
  localparam logic [11:0] LSD_POS_RST = 12'h001;
  localparam logic [11:0] LSD_END_RST = 12'h800;
  localparam logic [11:0] LSD_RB_END_MIN = 12'h002;
  localparam logic [10:0] LSD_N256 = 11'h100;
  localparam logic [10:0] LSD_N512 = 11'h200;
  localparam logic [10:0] LSD_N1024 = 11'h400;

  // Trailer constants.
  localparam logic [3:0] LSD_TR_LAST = 4'hf;
  localparam logic [7:0] LSD_PAT_A = 8'haa;
  localparam logic [7:0] LSD_PAT_5 = 8'h55;
  localparam logic [4:0] LSD_DIV_STEPS = 5'h18;

  typedef enum logic [1:0] {
    LSD_SRC_LIVE = 2'b00,
    LSD_SRC_RAMP = 2'b01,
    LSD_SRC_STEP = 2'b10
  } lsd_src_t;

  typedef enum logic [2:0] {
    LSD_RB_IDLE = 3'b000,
    LSD_RB_ARM = 3'b001,
    LSD_RB_CAPT = 3'b010,
    LSD_RB_DIV = 3'b011,
    LSD_RB_DONE = 3'b100
  } lsd_rb_t;

  // One video beat: line valid and pixel value.
  typedef struct packed {
    logic lval;
    logic [11:0] data;
  } lsd_beat_t;

endpackage

// ### lsd_grabber.sv
// Purpose: Frame grabber model that collects pixels and trailer words.
// Assumes: Trailer words follow one gap word after line valid falls.
// Notes: Behavioural; the pixel and word counts restart at each line start, the arrays keep old values.
`timescale 1ns/10ps
`default_nettype none
module lsd_grabber
  import lsd_pkg::*;
(
  // Clock, reset and video.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire lsd_beat_t vid_i,
  // Captured line.
  output logic [11:0] pix_o [64],
  output var int n_pix_o,
  output logic [11:0] words_o [16],
  output var int n_words_o
);
  int pos;
  logic prev;
  ////////////////////////////////////////////////////////////////////////
  // Sorts each beat into image pixels or trailer words; the beat right
  // after line valid falls is the gap word and is skipped.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pos <= 0;
      prev <= 1'b0;
      n_pix_o <= 0;
      n_words_o <= 0;
    end else begin
      prev <= vid_i.lval;
      if (vid_i.lval) begin
        pos <= 0;
        if (!prev) begin
          n_pix_o <= 1;
          n_words_o <= 0;
          pix_o[0] <= vid_i.data;
        end else begin
          if (n_pix_o < 64) pix_o[n_pix_o] <= vid_i.data;
          n_pix_o <= n_pix_o + 1;
        end
      end else if (prev) begin
        pos <= 1;
      end else if (pos != 0 && pos < 17) begin
        // Only beats with line valid low count as trailer words.
        words_o[pos-1] <= vid_i.data;
        n_words_o <= n_words_o + 1;
        pos <= pos + 1;
      end
    end
  end
endmodule // lsd_grabber
`default_nettype wire

// ### lsd_line_stats_tb.sv
// Purpose: Self-checking bench for the line statistics block.
// Assumes: Wishbone answers in a few cycles; lines of 40 pixels.
// Notes: Random pixels and thresholds come from a fixed-seed LFSR.
`timescale 1ns/10ps
`default_nettype none
module lsd_line_stats_tb;
  import lsd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, cnt;
  logic [31:0] dat_i = 32'h0, dat_o, rd, sm, seed = 32'hde2e;
  lsd_beat_t vid_i = '0, vid_o;
  logic [11:0] px [40], pix [64], words [16], up, lo, mn, mx;
  int n_pix, n_words, n_fail = 0, total_checks = 0, cyc_n = 0;
  int s = 3, e = 30;
  lsd_line_stats lsd_line_stats_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .vid_i(vid_i), .vid_o(vid_o));
  lsd_grabber lsd_grabber_inst (.clk_i(clk_i), .rst_i(rst_i),
    .vid_i(vid_o), .pix_o(pix), .n_pix_o(n_pix), .words_o(words),
    .n_words_o(n_words));
  ////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short.
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    // Only the cycle ceiling ends a wait for the acknowledge.
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Sends px as one line, then a gap of changing non-pixel data.
  task automatic line();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      vid_i <= {1'b1, px[i]};
    end
    repeat (26) begin
      @(posedge clk_i);
      vid_i <= {1'b0, 12'(rnd())};
    end
    cnt = cnt + 4'h1;
  endtask
  // Random pixels with both thresholds placed exactly in the ROI.
  task automatic fill();
    for (int i = 0; i < 40; i++) px[i] = 12'(rnd());
    px[5] = up;
    px[6] = lo;
  endtask
  // Works out the trailer of px and compares it with the captured one.
  task automatic trail(input logic on);
    logic [31:0] ab, bl, df;
    logic [11:0] ex [16];
    sm = 0;
    ab = 0;
    bl = 0;
    df = 0;
    mn = 12'hfff;
    mx = 12'h000;
    for (int i = s - 1; i < e; i++) begin
      sm += px[i];
      ab += {31'h0, px[i] > up};
      bl += {31'h0, px[i] < lo};
      if (px[i] < mn) mn = px[i];
      if (px[i] > mx) mx = px[i];
      if (i > s - 1) begin
        df += (px[i] > px[i-1]) ? px[i] - px[i-1] : px[i-1] - px[i];
      end
    end
    ex[0] = 12'h0aa;
    ex[1] = 12'h055;
    ex[2] = 12'h0aa;
    ex[3] = {8'h00, cnt - 4'h1};
    for (int k = 0; k < 4; k++) begin
      ex[4+k] = {4'h0, sm[8*k+:8]};
      ex[12+k] = {4'h0, df[8*k+:8]};
    end
    for (int k = 0; k < 2; k++) begin
      ex[8+k] = {4'h0, ab[8*k+:8]};
      ex[10+k] = {4'h0, bl[8*k+:8]};
    end
    check(n_pix, 40);
    if (on) begin
      check(n_words, 16);
      for (int k = 0; k < 3; k++) check(32'(words[k]), 32'(ex[k]));
      check(32'(words[3]), 32'(ex[3]));
      for (int k = 4; k < 8; k++) begin
        check(32'(words[k]), 32'(ex[k]));
      end
      for (int k = 8; k < 10; k++) begin
        check(32'(words[k]), 32'(ex[k]));
      end
      for (int k = 10; k < 12; k++) begin
        check(32'(words[k]), 32'(ex[k]));
      end
      for (int k = 12; k < 16; k++) begin
        check(32'(words[k]), 32'(ex[k]));
      end
    end else begin
      check({31'h0, words[0] == 12'h0aa && words[1] == 12'h055}, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [10:0] sv [4];
    logic [10:0] se [4];
    logic [31:0] av [40];
    sv = '{11'd300, LSD_N256, LSD_N512, LSD_N1024};
    se = '{LSD_N1024, LSD_N256, LSD_N512, LSD_N1024};
    cnt = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, LSD_CTRL, 0);
    check(rd, 32'h1);
    wb(0, LSD_UPPER, 0);
    check(rd, 32'hfff);
    wb(0, 8'h40, 0);
    check(rd, 32'h0);
    // Only three sample counts are accepted.
    for (int k = 0; k < 4; k++) begin
      wb(1, LSD_SAMPLES, {21'h0, sv[k]});
      wb(0, LSD_SAMPLES, 0);
      check(rd, {21'h0, se[k]});
    end
    wb(1, LSD_ROI, {4'h0, 12'(e), 4'h0, 12'(s)});
    // Trailers over random lines and thresholds, counter wraps.
    for (int n = 0; n < 19; n++) begin
      up = (n == 0) ? 12'h000 : 12'(rnd());
      lo = (n == 0) ? 12'hfff : 12'(rnd());
      wb(1, LSD_UPPER, {20'h0, up});
      wb(0, LSD_UPPER, 0);
      check(rd, {20'h0, up});
      wb(1, LSD_LOWER, {20'h0, lo});
      wb(0, LSD_LOWER, 0);
      check(rd, {20'h0, lo});
      fill();
      line();
      trail(1'b1);
      for (int i = 0; i < 40; i++) begin
        check(32'(pix[i]), 32'(px[i]));
      end
    end
    // The line counter register follows every line end.
    wb(0, LSD_LINECNT, 0);
    check(rd, {28'h0, cnt});
    wb(1, LSD_CTRL, 32'h0);
    fill();
    line();
    trail(1'b0);
    // Ramp, step, then a refused source code that keeps the step.
    for (int m = 1; m < 4; m++) begin
      wb(1, LSD_CTRL, {29'h0, 2'(m), 1'b1});
      line();
      for (int i = 0; i < 40; i++) begin
        check(32'(pix[i]), (m == 1) ? i : i >> 4);
      end
    end
    wb(1, LSD_CTRL, 32'h1);
    // Single-line readback of raw pixels with ROI statistics.
    wb(1, LSD_CMD, 32'h1);
    fill();
    line();
    trail(1'b1);
    for (int k = 0; k < 40 && !rd[1]; k++) wb(0, LSD_CMD, 0);
    check({31'h0, rd[1]}, 1);
    for (int i = 1; i <= 40; i += 13) begin
      wb(1, LSD_RBIDX, i);
      wb(0, LSD_RBDATA, 0);
      check(rd, {20'h0, px[i-1]});
    end
    wb(0, LSD_MINMAX, 0);
    check(rd, {4'h0, mx, 4'h0, mn});
    wb(0, LSD_MEAN, 0);
    check(rd, sm / (e - s + 1));
    wb(1, LSD_RBRANGE, {4'h0, 12'd5, 4'h0, 12'd10});
    wb(0, LSD_RBRANGE, 0);
    check(rd, {4'h0, 12'd5, 4'h0, 12'd10});
    // End below start: only the start pixel stays readable.
    wb(1, LSD_RBIDX, 32'd10);
    wb(0, LSD_RBDATA, 0);
    check(rd, {20'h0, px[9]});
    wb(1, LSD_RBIDX, 32'd11);
    wb(0, LSD_RBDATA, 0);
    check(rd, 32'h0);
    // Averaged readback over 256 random lines.
    wb(1, LSD_RBRANGE, {4'h0, 12'd40, 4'h0, 12'd1});
    wb(1, LSD_SAMPLES, {21'h0, LSD_N256});
    wb(1, LSD_CMD, 32'h2);
    for (int i = 0; i < 40; i++) av[i] = 32'h0;
    repeat (256) begin
      fill();
      line();
      for (int i = 0; i < 40; i++) av[i] += {20'h0, px[i]};
    end
    sm = 0;
    mn = 12'hfff;
    mx = 12'h000;
    for (int i = 0; i < 40; i++) begin
      av[i] = av[i] >> 8;
      if (i >= s - 1 && i < e) begin
        sm += av[i];
        if (av[i][11:0] < mn) mn = av[i][11:0];
        if (av[i][11:0] > mx) mx = av[i][11:0];
      end
    end
    // The earlier command left done set in rd; poll afresh.
    rd = 32'h0;
    for (int k = 0; k < 40 && !rd[1]; k++) wb(0, LSD_CMD, 0);
    check({31'h0, rd[1]}, 1);
    for (int i = 1; i <= 40; i += 7) begin
      wb(1, LSD_RBIDX, i);
      wb(0, LSD_RBDATA, 0);
      check(rd, av[i-1]);
    end
    wb(0, LSD_MINMAX, 0);
    check(rd, {4'h0, mx, 4'h0, mn});
    wb(0, LSD_MEAN, 0);
    check(rd, sm / (e - s + 1));
    report_and_stop();
  end
endmodule // lsd_line_stats_tb
`default_nettype wire
